// ---- bzt_front_model.sv ----
// Purpose: Measurement front end model that paces the zone with sample ticks.
// Assumes: One tick every second clock cycle.
// Notes: Ticks stop while reset is held.
`timescale 1ns/10ps

module bzt_front_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Pacing.
  output logic sample_tick
);
  initial sample_tick = 1'b0;
  always @(negedge clk) begin
    sample_tick <= reset_n & ~sample_tick;
  end
endmodule

// ---- bzt_on_delay.sv ----
// Purpose: On-delay timer counting millisecond ticks while its input holds.
// Assumes: ms_tick is a one-cycle pulse on clk.
// Notes: A zero delay gives the output on the cycle after the input rises.
`timescale 1ns/10ps

module bzt_on_delay
  import bzt_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Timing.
  input wire logic ms_tick,
  input wire logic [TIME_W-1:0] delay_ms,
  // Condition and result.
  input wire logic run,
  output logic done
);

  logic [TIME_W-1:0] count;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (ms_tick && count < delay_ms) begin
      count <= count + 23'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else begin
      done <= run && (count >= delay_ms);
    end
  end

endmodule

// ---- bzt_open_ct_latch.sv ----
// Purpose: Latches one open CT detection of one phase and derives its inhibit.
// Assumes: detect is already qualified by the start level and any delay.
// Notes: A new detection wins over a clear in the same cycle.
`timescale 1ns/10ps

module bzt_open_ct_latch
  import bzt_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Settings.
  input wire bzt_oct_mode_t mode,
  // Conditions.
  input wire logic detect,
  input wire logic clear_allowed,
  input wire logic above_release,
  // Results.
  output logic flag,
  output logic inhibit
);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (mode == BZT_OCT_OFF) begin
      flag <= 1'b0;
    end else if (detect) begin
      flag <= 1'b1;
    end else if (clear_allowed) begin
      flag <= 1'b0;
    end
  end

  always_comb begin
    case (mode)
      BZT_OCT_BLOCK: inhibit = flag;
      BZT_OCT_SUPERVISE: inhibit = flag && !above_release;
      default: inhibit = 1'b0;
    endcase
  end

endmodule

// ---- bzt_pkg.sv ----
// Purpose: Shared constants and types for the busbar zone trip logic.
// Assumes: Currents are unsigned primary amperes; times are whole milliseconds.
// Notes: Contract list of the zone behaviour follows.
//
// Contract
// - General trip on differential, sensitive, bay external or zone external trip.
// - Flag trips caused by an external trip from a connected bay.
// - Flag trips caused by the zone external trip input.
// - Flag trips caused by sensitive differential, per phase and overall.
// - Open CT alarm when fast or slow detection operates.
// - Separate slow and fast open CT flags, per phase.
// - Differential and incoming current alarms, per phase.
// - Output incoming, differential and fundamental RMS values, recorder and report.
// - Operation Off removes every protection action; here latched open CT flags and open_ct_alarm stay set.
// - Differential start only above start level, default 1000 A.
// - Self-reset mode drops trip after hold time.
// - Latched mode holds trip until manual reset.
// - Hold time 0 to 60000 ms, default 200 ms.
// - Check zone supervision On requires check zone operation for differential trip.
// - Open CT modes Off, Block, Supervise per algorithm; Block inhibits per phase.
// - Supervise re-allows differential above release level, default 2500 A.
// - One open CT start level for both algorithms, default 200 A.
// - Slow open CT delay up to 6000 s, default 20 s.
// - Differential alarm after level held for delay, 200 A, 30 s.
// - Incoming current alarm without delay above level, default 3000 A.
// - Sensitive operates only when On, enabled and above level, 200 A.
// - Sensitive blocked above incoming level 1000 A, else delayed 400 ms.
// - Trip block suppresses trips; start block stops differential operation.
// - Trip reset input clears a latched trip.
// - Open CT reset clears latches only while differential below start level.

package bzt_pkg;

  localparam int CUR_W = 16;
  localparam int TIME_W = 23;
  localparam int PHASES = 3;

  localparam logic [CUR_W-1:0] DIFF_START_LEVEL_RST = 16'h03E8;
  localparam logic [CUR_W-1:0] OPEN_CT_RELEASE_LEVEL_RST = 16'h09C4;
  localparam logic [CUR_W-1:0] OPEN_CT_START_LEVEL_RST = 16'h00C8;
  localparam logic [CUR_W-1:0] DIFF_ALARM_LEVEL_RST = 16'h00C8;
  localparam logic [CUR_W-1:0] INCOMING_ALARM_LEVEL_RST = 16'h0BB8;
  localparam logic [CUR_W-1:0] SENSITIVE_START_LEVEL_RST = 16'h00C8;
  localparam logic [CUR_W-1:0] SENSITIVE_INHIBIT_LEVEL_RST = 16'h03E8;

  localparam logic [TIME_W-1:0] TRIP_HOLD_TIME_RST = 23'h0000C8;
  localparam logic [TIME_W-1:0] TRIP_HOLD_TIME_MAX = 23'h00EA60;
  localparam logic [TIME_W-1:0] SLOW_OPEN_CT_DELAY_RST = 23'h004E20;
  localparam logic [TIME_W-1:0] DIFF_ALARM_DELAY_RST = 23'h007530;
  localparam logic [TIME_W-1:0] SENSITIVE_DELAY_RST = 23'h000190;
  localparam logic [TIME_W-1:0] LONG_DELAY_MAX = 23'h5B8D80;
  localparam logic [TIME_W-1:0] SENSITIVE_DELAY_MAX = 23'h00EA60;

  localparam int CLK_HZ = 50000000;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = (CLK_HZ / 1000000) * MS_TICK_NS / 1000;

  typedef enum logic [1:0] {
    BZT_OCT_OFF = 2'b00,
    BZT_OCT_BLOCK = 2'b01,
    BZT_OCT_SUPERVISE = 2'b10
  } bzt_oct_mode_t;

  typedef enum logic {
    BZT_AUTO_CLEAR = 1'b0,
    BZT_LATCHED = 1'b1
  } bzt_trip_mode_t;

  function automatic logic bzt_above(input logic [CUR_W-1:0] value,
                                     input logic [CUR_W-1:0] setting);
    return value > setting;
  endfunction

  function automatic logic [TIME_W-1:0] bzt_clamp(input logic [TIME_W-1:0] t,
                                                  input logic [TIME_W-1:0] lim);
    return (t > lim) ? lim : t;
  endfunction

endpackage

// ---- bzt_zone.sv ----
// Purpose: Trip decision, open CT handling, alarms and value outputs of one zone.
// Assumes: Inputs come from logic on clk; currents are updated by the front end.
// Notes: Three-phase form; general flags are the OR of the phase flags.
`timescale 1ns/10ps

module bzt_zone
  import bzt_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
)
(
  // Clock, reset and pacing.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_tick,
  // Measured currents per phase.
  input wire logic [PHASES-1:0][CUR_W-1:0] diff_current,
  input wire logic [PHASES-1:0][CUR_W-1:0] incoming_current,
  input wire logic [PHASES-1:0][CUR_W-1:0] diff_fundamental,
  // Detection sources.
  input wire logic [PHASES-1:0] check_zone_operate,
  input wire logic [PHASES-1:0] fast_open_ct_detect,
  input wire logic [PHASES-1:0] slow_open_ct_detect,
  input wire logic bay_external_trip_in,
  // Control inputs.
  input wire logic external_zone_trip_in,
  input wire logic trip_block_in,
  input wire logic diff_start_inhibit_in,
  input wire logic latched_trip_clear_in,
  input wire logic open_ct_clear_in,
  input wire logic sensitive_enable_in,
  // Settings.
  input wire logic operation_on,
  input wire bzt_trip_mode_t trip_output_mode,
  input wire logic check_zone_supervision,
  input wire bzt_oct_mode_t slow_open_ct_mode,
  input wire bzt_oct_mode_t fast_open_ct_mode,
  input wire logic sensitive_function_mode,
  input wire logic [CUR_W-1:0] diff_start_level,
  input wire logic [CUR_W-1:0] open_ct_release_level,
  input wire logic [CUR_W-1:0] open_ct_start_level,
  input wire logic [CUR_W-1:0] diff_alarm_level,
  input wire logic [CUR_W-1:0] incoming_alarm_level,
  input wire logic [CUR_W-1:0] sensitive_start_level,
  input wire logic [CUR_W-1:0] sensitive_inhibit_level,
  input wire logic [TIME_W-1:0] trip_hold_time,
  input wire logic [TIME_W-1:0] slow_open_ct_delay,
  input wire logic [TIME_W-1:0] diff_alarm_delay,
  input wire logic [TIME_W-1:0] sensitive_delay,
  // Trip outputs.
  output logic zone_trip,
  output logic [PHASES-1:0] zone_trip_phase,
  output logic trip_cause_bay_external,
  output logic trip_cause_zone_external,
  output logic trip_cause_sensitive,
  output logic [PHASES-1:0] trip_cause_sensitive_per_phase,
  // Open CT and alarm outputs.
  output logic open_ct_alarm,
  output logic [PHASES-1:0] open_ct_slow_flag_per_phase,
  output logic [PHASES-1:0] open_ct_fast_flag_per_phase,
  output logic [PHASES-1:0] diff_current_alarm_per_phase,
  output logic [PHASES-1:0] incoming_current_alarm_per_phase,
  // Value outputs.
  output logic [PHASES-1:0][CUR_W-1:0] incoming_rms_value_per_phase,
  output logic [PHASES-1:0][CUR_W-1:0] incoming_rms_report_per_phase,
  output logic [PHASES-1:0][CUR_W-1:0] diff_rms_value_per_phase,
  output logic [PHASES-1:0][CUR_W-1:0] diff_rms_report_per_phase,
  output logic [PHASES-1:0][CUR_W-1:0] diff_fundamental_rms_per_phase
);

  // ********************************************************************
  // Millisecond time base for all delay timers.
  // ********************************************************************

  logic [31:0] ms_count;
  logic ms_tick;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ms_count <= '0;
    end else if (ms_count >= 32'(MS_CYCLES - 1)) begin
      ms_count <= '0;
    end else begin
      ms_count <= ms_count + 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_count >= 32'(MS_CYCLES - 1));
    end
  end

  logic [TIME_W-1:0] hold_ms;
  logic [TIME_W-1:0] slow_ms;
  logic [TIME_W-1:0] alarm_ms;
  logic [TIME_W-1:0] sens_ms;

  // Out-of-range settings are clamped to the top of their range.
  assign hold_ms = bzt_clamp(trip_hold_time, TRIP_HOLD_TIME_MAX);
  assign slow_ms = bzt_clamp(slow_open_ct_delay, LONG_DELAY_MAX);
  assign alarm_ms = bzt_clamp(diff_alarm_delay, LONG_DELAY_MAX);
  assign sens_ms = bzt_clamp(sensitive_delay, SENSITIVE_DELAY_MAX);

  // ********************************************************************
  // Level comparisons, refreshed once per sample tick.
  // ********************************************************************

  logic [PHASES-1:0] id_above_start;
  logic [PHASES-1:0] id_above_release;
  logic [PHASES-1:0] id_above_oct;
  logic [PHASES-1:0] id_above_alarm;
  logic [PHASES-1:0] id_above_sens;
  logic [PHASES-1:0] iin_above_alarm;
  logic [PHASES-1:0] iin_above_sens_block;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      id_above_start <= '0;
      id_above_release <= '0;
      id_above_oct <= '0;
      id_above_alarm <= '0;
      id_above_sens <= '0;
      iin_above_alarm <= '0;
      iin_above_sens_block <= '0;
    end else if (sample_tick) begin
      for (int p = 0; p < PHASES; p++) begin
        id_above_start[p] <= bzt_above(diff_current[p], diff_start_level);
        id_above_release[p] <= bzt_above(diff_current[p], open_ct_release_level);
        id_above_oct[p] <= bzt_above(diff_current[p], open_ct_start_level);
        id_above_alarm[p] <= bzt_above(diff_current[p], diff_alarm_level);
        id_above_sens[p] <= bzt_above(diff_current[p], sensitive_start_level);
        iin_above_alarm[p] <= bzt_above(incoming_current[p], incoming_alarm_level);
        iin_above_sens_block[p] <= bzt_above(incoming_current[p],
                                             sensitive_inhibit_level);
      end
    end
  end

  // ********************************************************************
  // Per-phase open CT latches, sensitive delay and differential alarm.
  // ********************************************************************

  logic [PHASES-1:0] slow_delayed;
  logic [PHASES-1:0] sens_op;
  logic [PHASES-1:0] fast_flag;
  logic [PHASES-1:0] slow_flag;
  logic [PHASES-1:0] fast_inhibit;
  logic [PHASES-1:0] slow_inhibit;
  logic [PHASES-1:0] alarm_done;
  logic [PHASES-1:0] oct_clear_ok;

  // Open CT latches may only be cleared while the differential is small.
  assign oct_clear_ok = open_ct_clear_in ? ~id_above_start : '0;

  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    bzt_on_delay u_slow_delay (
      .clk(clk),
      .reset_n(reset_n),
      .ms_tick(ms_tick),
      .delay_ms(slow_ms),
      .run(operation_on && slow_open_ct_detect[p] && id_above_oct[p]),
      .done(slow_delayed[p])
    );

    bzt_open_ct_latch u_slow_latch (
      .clk(clk),
      .reset_n(reset_n),
      .mode(slow_open_ct_mode),
      .detect(slow_delayed[p]),
      .clear_allowed(oct_clear_ok[p]),
      .above_release(id_above_release[p]),
      .flag(slow_flag[p]),
      .inhibit(slow_inhibit[p])
    );

    bzt_open_ct_latch u_fast_latch (
      .clk(clk),
      .reset_n(reset_n),
      .mode(fast_open_ct_mode),
      .detect(operation_on && fast_open_ct_detect[p] && id_above_oct[p]),
      .clear_allowed(oct_clear_ok[p]),
      .above_release(id_above_release[p]),
      .flag(fast_flag[p]),
      .inhibit(fast_inhibit[p])
    );

    bzt_on_delay u_sens_delay (
      .clk(clk),
      .reset_n(reset_n),
      .ms_tick(ms_tick),
      .delay_ms(sens_ms),
      .run(operation_on && sensitive_function_mode && sensitive_enable_in
           && id_above_sens[p] && !iin_above_sens_block[p]),
      .done(sens_op[p])
    );

    bzt_on_delay u_alarm_delay (
      .clk(clk),
      .reset_n(reset_n),
      .ms_tick(ms_tick),
      .delay_ms(alarm_ms),
      .run(operation_on && id_above_alarm[p]),
      .done(alarm_done[p])
    );
  end

  // ********************************************************************
  // Trip request per phase.
  // ********************************************************************

  logic [PHASES-1:0] diff_op;
  logic [PHASES-1:0] trip_req;
  logic any_trip_req;
  logic zone_active;

  assign zone_active = operation_on && !trip_block_in;

  always_comb begin
    for (int p = 0; p < PHASES; p++) begin
      diff_op[p] = operation_on && !diff_start_inhibit_in && id_above_start[p]
                   && (!check_zone_supervision || check_zone_operate[p])
                   && !slow_inhibit[p] && !fast_inhibit[p];
      trip_req[p] = zone_active && (diff_op[p] || sens_op[p]
                    || bay_external_trip_in || external_zone_trip_in);
    end
  end

  assign any_trip_req = |trip_req;

  // ********************************************************************
  // Trip hold: latched or self-resetting after the hold time.
  // ********************************************************************

  logic [TIME_W-1:0] hold_count;
  logic hold_expired;
  logic [PHASES-1:0] next_trip_phase;
  logic next_cause_bay;
  logic next_cause_zone;
  logic [PHASES-1:0] next_cause_sens;

  assign hold_expired = (hold_count >= hold_ms);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_count <= '0;
    end else if (any_trip_req || trip_output_mode == BZT_LATCHED) begin
      hold_count <= '0;
    end else if (ms_tick && !hold_expired) begin
      hold_count <= hold_count + 23'h000001;
    end
  end

  always_comb begin
    next_trip_phase = zone_trip_phase;
    next_cause_bay = trip_cause_bay_external;
    next_cause_zone = trip_cause_zone_external;
    next_cause_sens = trip_cause_sensitive_per_phase;
    if (!zone_active) begin
      next_trip_phase = '0;
      next_cause_bay = 1'b0;
      next_cause_zone = 1'b0;
      next_cause_sens = '0;
    end else if (any_trip_req) begin
      // A new request wins over a reset arriving in the same cycle.
      next_trip_phase = zone_trip_phase | trip_req;
      next_cause_bay = trip_cause_bay_external || bay_external_trip_in;
      next_cause_zone = trip_cause_zone_external || external_zone_trip_in;
      next_cause_sens = trip_cause_sensitive_per_phase | sens_op;
    end else if ((trip_output_mode == BZT_LATCHED && latched_trip_clear_in)
                 || (trip_output_mode == BZT_AUTO_CLEAR && hold_expired)) begin
      next_trip_phase = '0;
      next_cause_bay = 1'b0;
      next_cause_zone = 1'b0;
      next_cause_sens = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      zone_trip_phase <= '0;
      zone_trip <= 1'b0;
      trip_cause_bay_external <= 1'b0;
      trip_cause_zone_external <= 1'b0;
      trip_cause_sensitive_per_phase <= '0;
      trip_cause_sensitive <= 1'b0;
    end else begin
      zone_trip_phase <= next_trip_phase;
      zone_trip <= |next_trip_phase;
      trip_cause_bay_external <= next_cause_bay;
      trip_cause_zone_external <= next_cause_zone;
      trip_cause_sensitive_per_phase <= next_cause_sens;
      trip_cause_sensitive <= |next_cause_sens;
    end
  end

  // ********************************************************************
  // Open CT flags and supervision alarms.
  // ********************************************************************

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      open_ct_alarm <= 1'b0;
      open_ct_slow_flag_per_phase <= '0;
      open_ct_fast_flag_per_phase <= '0;
      diff_current_alarm_per_phase <= '0;
      incoming_current_alarm_per_phase <= '0;
    end else begin
      open_ct_alarm <= |(slow_flag | fast_flag);
      open_ct_slow_flag_per_phase <= slow_flag;
      open_ct_fast_flag_per_phase <= fast_flag;
      diff_current_alarm_per_phase <= alarm_done;
      incoming_current_alarm_per_phase <= operation_on ? iin_above_alarm : '0;
    end
  end

  // ********************************************************************
  // Measured values for recorder and reporting.
  // ********************************************************************

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      incoming_rms_value_per_phase <= '0;
      incoming_rms_report_per_phase <= '0;
      diff_rms_value_per_phase <= '0;
      diff_rms_report_per_phase <= '0;
      diff_fundamental_rms_per_phase <= '0;
    end else if (sample_tick) begin
      incoming_rms_value_per_phase <= incoming_current;
      incoming_rms_report_per_phase <= incoming_current;
      diff_rms_value_per_phase <= diff_current;
      diff_rms_report_per_phase <= diff_current;
      diff_fundamental_rms_per_phase <= diff_fundamental;
    end
  end

endmodule

// ---- bzt_zone_props.sv ----
// Purpose: Port-level checker of the zone trip logic.
// Assumes: One clock domain with synchronous active-low reset.
// Notes: Bound to every bzt_zone instance.
`timescale 1ns/10ps

module bzt_zone_props
  import bzt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire logic [PHASES-1:0][CUR_W-1:0] diff_current,
  input wire logic [PHASES-1:0][CUR_W-1:0] incoming_current,
  input wire logic bay_external_trip_in,
  input wire logic external_zone_trip_in,
  input wire logic trip_block_in,
  input wire logic latched_trip_clear_in,
  input wire logic operation_on,
  input wire bzt_trip_mode_t trip_output_mode,
  input wire logic [CUR_W-1:0] incoming_alarm_level,
  input wire logic zone_trip,
  input wire logic [PHASES-1:0] zone_trip_phase,
  input wire logic trip_cause_bay_external,
  input wire logic trip_cause_zone_external,
  input wire logic trip_cause_sensitive,
  input wire logic open_ct_alarm,
  input wire logic [PHASES-1:0] open_ct_slow_flag_per_phase,
  input wire logic [PHASES-1:0] open_ct_fast_flag_per_phase,
  input wire logic [PHASES-1:0] incoming_current_alarm_per_phase,
  input wire logic [PHASES-1:0][CUR_W-1:0] incoming_rms_report_per_phase,
  input wire logic [PHASES-1:0][CUR_W-1:0] diff_rms_value_per_phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_live;
    operation_on && !trip_block_in;
  endsequence
  a_trip_block: assert property (trip_block_in |=> !zone_trip && !trip_cause_sensitive)
    else $error("trip seen while blocked");
  a_op_off: assert property (!operation_on |=> !zone_trip && !trip_cause_bay_external)
    else $error("trip seen while out of operation");
  a_zone_ext: assert property (external_zone_trip_in ##0 s_live
    |=> zone_trip && trip_cause_zone_external && zone_trip_phase == 3'h7)
    else $error("zone external trip missing");
  a_bay_ext: assert property (bay_external_trip_in ##0 s_live
    |=> zone_trip && trip_cause_bay_external) else $error("bay external trip missing");
  a_trip_or: assert property (zone_trip == (|zone_trip_phase))
    else $error("general trip differs from phase trips");
  a_oct_or: assert property (open_ct_alarm ==
    (|{open_ct_slow_flag_per_phase, open_ct_fast_flag_per_phase}))
    else $error("open ct alarm differs from flags");
  a_inc_alarm: assert property (sample_tick && operation_on
    && incoming_current[1] > incoming_alarm_level
    |-> ##[1:3] incoming_current_alarm_per_phase[1]) else $error("incoming alarm missing");
  a_value_copy: assert property (sample_tick |=>
    diff_rms_value_per_phase == $past(diff_current)
    && incoming_rms_report_per_phase == $past(incoming_current))
    else $error("value outputs not refreshed");
  a_latched_hold: assert property (trip_output_mode == BZT_LATCHED && zone_trip
    && !latched_trip_clear_in ##0 s_live |=> zone_trip) else $error("latched trip dropped");
  a_sens_cause: assert property (trip_cause_sensitive |-> zone_trip)
    else $error("sensitive cause without trip");
  c_trip: cover property ($rose(zone_trip));
  c_oct: cover property ($rose(open_ct_alarm));
  c_sens: cover property ($rose(trip_cause_sensitive));
endmodule

bind bzt_zone bzt_zone_props props (.*);

// ---- tb_top.sv ----
// Purpose: Directed testbench of the zone trip logic.
// Assumes: MS_CYCLES of 5, so one millisecond is five clocks.
// Notes: Inputs change on the falling edge.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module tb_top;
  import bzt_pkg::*;
  // ************
  // Stimulus and observation
  // ************
  logic clk = 1'b0, reset_n = 1'b0, sample_tick;
  logic [PHASES-1:0][CUR_W-1:0] diff_current = '0, incoming_current = '0, diff_fundamental;
  logic [PHASES-1:0] check_zone_operate = '0, fast_open_ct_detect = '0;
  logic [PHASES-1:0] slow_open_ct_detect = '0;
  logic bay_external_trip_in = 0, external_zone_trip_in = 0, trip_block_in = 0;
  logic diff_start_inhibit_in = 0, latched_trip_clear_in = 0, open_ct_clear_in = 0;
  logic sensitive_enable_in = 0, operation_on = 1, check_zone_supervision = 0;
  logic sensitive_function_mode = 1;
  bzt_trip_mode_t trip_output_mode = BZT_AUTO_CLEAR;
  bzt_oct_mode_t slow_open_ct_mode = BZT_OCT_OFF, fast_open_ct_mode = BZT_OCT_BLOCK;
  logic [CUR_W-1:0] diff_start_level = DIFF_START_LEVEL_RST;
  logic [CUR_W-1:0] open_ct_release_level = OPEN_CT_RELEASE_LEVEL_RST;
  logic [CUR_W-1:0] open_ct_start_level = OPEN_CT_START_LEVEL_RST;
  logic [CUR_W-1:0] diff_alarm_level = DIFF_ALARM_LEVEL_RST;
  logic [CUR_W-1:0] incoming_alarm_level = INCOMING_ALARM_LEVEL_RST;
  logic [CUR_W-1:0] sensitive_start_level = SENSITIVE_START_LEVEL_RST;
  logic [CUR_W-1:0] sensitive_inhibit_level = SENSITIVE_INHIBIT_LEVEL_RST;
  logic [TIME_W-1:0] trip_hold_time = 23'h000002, slow_open_ct_delay = 23'h000004;
  logic [TIME_W-1:0] diff_alarm_delay = 23'h000004, sensitive_delay = 23'h000004;
  logic zone_trip, trip_cause_bay_external, trip_cause_zone_external, trip_cause_sensitive;
  logic open_ct_alarm;
  logic [PHASES-1:0] zone_trip_phase, trip_cause_sensitive_per_phase;
  logic [PHASES-1:0] open_ct_slow_flag_per_phase, open_ct_fast_flag_per_phase;
  logic [PHASES-1:0] diff_current_alarm_per_phase, incoming_current_alarm_per_phase;
  logic [PHASES-1:0][CUR_W-1:0] incoming_rms_value_per_phase, incoming_rms_report_per_phase;
  logic [PHASES-1:0][CUR_W-1:0] diff_rms_value_per_phase, diff_rms_report_per_phase;
  logic [PHASES-1:0][CUR_W-1:0] diff_fundamental_rms_per_phase;
  int err_count = 0, num_checks = 0, cyc_count = 0;

  assign diff_fundamental = {16'h0ABC, 16'h1234, 16'h0056};
  bzt_front_model front (.clk(clk), .reset_n(reset_n), .sample_tick(sample_tick));
  bzt_zone #(.MS_CYCLES(5)) uut (.*);

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      err_count++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic oct_detect(input int p);
    fast_open_ct_detect[p] = 1'b1;
    cyc(6);
    fast_open_ct_detect[p] = 1'b0;
    cyc(2);
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ************
  // Test sequence
  // ************
  initial begin
    cyc(12);
    reset_n = 1'b1;
    cyc(1);
    `CHK("trip_rst", 1'b0, zone_trip)
    external_zone_trip_in = 1'b1;
    cyc(3);
    `CHK("ext_phase", 3'h7, zone_trip_phase)
    `CHK("ext_cause", 1'b1, trip_cause_zone_external)
    external_zone_trip_in = 1'b0;
    cyc(4);
    `CHK("hold_on", 1'b1, zone_trip)
    cyc(20);
    `CHK("hold_off", 1'b0, zone_trip)
    trip_output_mode = BZT_LATCHED;
    bay_external_trip_in = 1'b1;
    cyc(3);
    bay_external_trip_in = 1'b0;
    cyc(30);
    `CHK("bay_cause", 1'b1, trip_cause_bay_external)
    latched_trip_clear_in = 1'b1;
    cyc(3);
    latched_trip_clear_in = 1'b0;
    `CHK("latch_clr", 1'b0, zone_trip)
    external_zone_trip_in = 1'b1;
    cyc(2);
    external_zone_trip_in = 1'b0;
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    `CHK("latch_rst", 1'b0, zone_trip)
    trip_output_mode = BZT_AUTO_CLEAR;
    trip_block_in = 1'b1;
    external_zone_trip_in = 1'b1;
    cyc(4);
    `CHK("blocked", 1'b0, zone_trip)
    trip_block_in = 1'b0;
    external_zone_trip_in = 1'b0;
    operation_on = 1'b0;
    bay_external_trip_in = 1'b1;
    cyc(4);
    `CHK("op_off", 1'b0, zone_trip)
    bay_external_trip_in = 1'b0;
    operation_on = 1'b1;
    diff_current[1] = 16'h03E8;
    cyc(6);
    `CHK("at_level", 1'b0, zone_trip_phase[1])
    `CHK("val_copy", 16'h03E8, diff_rms_report_per_phase[1])
    `CHK("fund_copy", 16'h1234, diff_fundamental_rms_per_phase[1])
    diff_current[1] = 16'h03E9;
    cyc(6);
    `CHK("above_lvl", 1'b1, zone_trip_phase[1])
    diff_start_inhibit_in = 1'b1;
    diff_current[1] = 16'h0000;
    cyc(25);
    diff_current[0] = 16'h03E9;
    cyc(6);
    `CHK("start_inh", 1'b0, zone_trip)
    diff_start_inhibit_in = 1'b0;
    check_zone_supervision = 1'b1;
    cyc(6);
    `CHK("cz_absent", 1'b0, zone_trip)
    check_zone_operate[0] = 1'b1;
    cyc(6);
    `CHK("cz_present", 1'b1, zone_trip)
    check_zone_operate[0] = 1'b0;
    check_zone_supervision = 1'b0;
    diff_current[0] = 16'h012C;
    sensitive_enable_in = 1'b1;
    cyc(10);
    `CHK("sens_wait", 1'b0, trip_cause_sensitive_per_phase[0])
    cyc(35);
    `CHK("sens_trip", 1'b1, trip_cause_sensitive_per_phase[0])
    incoming_current[0] = 16'h03E9;
    cyc(40);
    `CHK("sens_inhib", 1'b0, trip_cause_sensitive)
    incoming_current[0] = 16'h0000;
    sensitive_enable_in = 1'b0;
    diff_current[2] = 16'h012C;
    oct_detect(2);
    `CHK("fast_flag", 1'b1, open_ct_fast_flag_per_phase[2])
    `CHK("oct_alarm", 1'b1, open_ct_alarm)
    diff_current[2] = 16'h0BB9;
    cyc(6);
    `CHK("oct_block", 1'b0, zone_trip_phase[2])
    diff_current[2] = 16'h012C;
    open_ct_clear_in = 1'b1;
    cyc(4);
    open_ct_clear_in = 1'b0;
    `CHK("oct_clear", 1'b0, open_ct_alarm)
    fast_open_ct_mode = BZT_OCT_SUPERVISE;
    oct_detect(2);
    diff_current[2] = 16'h09C4;
    cyc(6);
    `CHK("sup_hold", 1'b0, zone_trip_phase[2])
    diff_current[2] = 16'h09C5;
    cyc(6);
    `CHK("sup_rel", 1'b1, zone_trip_phase[2])
    diff_current = '0;
    diff_current[1] = 16'h012C;
    incoming_current[1] = 16'h0BB9;
    cyc(6);
    `CHK("inc_alarm", 1'b1, incoming_current_alarm_per_phase[1])
    `CHK("iin_copy", 16'h0BB9, incoming_rms_value_per_phase[1])
    `CHK("dif_wait", 1'b0, diff_current_alarm_per_phase[1])
    incoming_current[1] = 16'h0BB8;
    cyc(40);
    `CHK("inc_drop", 1'b0, incoming_current_alarm_per_phase[1])
    `CHK("dif_alarm", 1'b1, diff_current_alarm_per_phase[1])
    slow_open_ct_mode = BZT_OCT_BLOCK;
    slow_open_ct_detect[1] = 1'b1;
    cyc(10);
    `CHK("slow_wait", 1'b0, open_ct_slow_flag_per_phase[1])
    cyc(20);
    `CHK("slow_flag", 1'b1, open_ct_slow_flag_per_phase[1])
    results();
  end
endmodule
